//--- include/mmc_pkg.sv
// Package of constants for the magnetometer measurement control block
package mmc_pkg;
  // Register addresses
  localparam logic [7:0] MMC_ADDR_CTRL_ONE = 8'h10;
  localparam logic [7:0] MMC_ADDR_CTRL_TWO = 8'h11;
  localparam logic [7:0] MMC_ADDR_SYS_STATE = 8'h08;
  // Burst address range of the axis data
  localparam logic [7:0] MMC_ADDR_DATA_LAST = 8'h06;
  localparam logic [7:0] MMC_ADDR_DATA_FIRST = 8'h01;
  // Field positions, first control register
  localparam int MMC_RATE_HI = 7;
  localparam int MMC_RATE_LO = 5;
  localparam int MMC_OVS_HI = 4;
  localparam int MMC_OVS_LO = 3;
  localparam int MMC_FAST_BIT = 2;
  localparam int MMC_TRIG_BIT = 1;
  localparam int MMC_RUN_BIT = 0;
  // Field positions, second control register
  localparam int MMC_AUTO_BIT = 7;
  localparam int MMC_RAW_BIT = 5;
  localparam int MMC_SRST_BIT = 4;
  // Reset values
  localparam logic [7:0] MMC_CTRL_ONE_RST = 8'h00;
  localparam logic [2:0] MMC_RATE_RST = 3'h0;
  localparam logic [1:0] MMC_OVS_RST = 2'h0;
  // System state codes
  localparam logic [1:0] MMC_SYS_STANDBY = 2'h0;
  localparam logic [1:0] MMC_SYS_ACT_RAW = 2'h1;
  localparam logic [1:0] MMC_SYS_ACT_COR = 2'h2;
  // Converter sample rate and clock rate
  localparam int MMC_CLK_HZ = 125000000;
  localparam int MMC_ADC_HZ = 1280;
  localparam int MMC_ADC_TICK_CYC = MMC_CLK_HZ / MMC_ADC_HZ;
  // Smallest oversampling ratio, as a power of two
  localparam int MMC_OVS_BASE_LOG2 = 4;
  // Sensor reset cycle length in converter ticks
  localparam int MMC_SRST_TICKS = 2;
  // Sequencer states
  typedef enum logic [1:0] {
    MMC_IDLE,
    MMC_SRST,
    MMC_MEAS,
    MMC_WAIT
  } mmc_state_t;
endpackage : mmc_pkg

//--- rtl/mmc_measure_control.sv
// Measurement control of a three-axis magnetic sensor
`timescale 1ns/1ps
`default_nettype none
module mmc_measure_control
  import mmc_pkg::*;
  #(
    parameter int ADC_TICK_CYC = MMC_ADC_TICK_CYC
  ) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register access port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Burst address step
  input wire logic burst_step_in,
  input wire logic [7:0] burst_addr_in,
  output logic [7:0] burst_next_out,
  // Measurement front end
  output logic meas_start_out,
  output logic sensor_refresh_out,
  output logic offset_add_out,
  output logic [1:0] system_state_out,
  output logic meas_done_out
  );

  // Control fields
  logic [2:0] rate_sel; // Data-rate code
  logic [1:0] oversample_sel; // Oversampling code
  logic fast_read_sel; // Skip low bytes in bursts
  logic trigger_meas; // One-shot request pending
  logic run_select; // Active when set
  logic auto_sensor_refresh_on; // Refresh before acquisitions
  logic raw_sel; // Leave outputs uncorrected
  logic srst_req; // Manual sensor reset pending or running
  // Sequencer
  mmc_state_t state;
  logic [16:0] tick_cnt; // Converter tick divider, holds the 97656-cycle count of one tick at 125 MHz
  logic adc_tick; // One-cycle converter tick
  logic [10:0] meas_cnt; // Ticks left in this phase
  // Ticks left before next measurement; slowest period is 128 times 128
  logic [14:0] gap_cnt;
  logic one_shot; // Current measurement is a lone trigger
  logic wr_one;
  logic wr_two;

  // Ticks per measurement for a given oversampling code
  function automatic logic [10:0] mmc_ovs_ticks(input logic [1:0] os);
    mmc_ovs_ticks = 11'(1 << (MMC_OVS_BASE_LOG2 + int'(os)));
  endfunction : mmc_ovs_ticks

  // Ticks per output period: ratio times two to the rate code
  // Wide enough for the slowest rate and the largest ratio together
  function automatic logic [14:0] mmc_period_ticks(input logic [1:0] os,
                                                   input logic [2:0] dr);
    mmc_period_ticks = 15'(32'(mmc_ovs_ticks(os)) << dr);
  endfunction : mmc_period_ticks

  assign wr_one = reg_wr_in && (reg_addr_in == MMC_ADDR_CTRL_ONE);
  assign wr_two = reg_wr_in && (reg_addr_in == MMC_ADDR_CTRL_TWO);

  // Divider giving the 1280 Hz converter tick
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= '0;
      adc_tick <= 1'b0;
    end else if (tick_cnt == 17'(ADC_TICK_CYC - 1)) begin
      tick_cnt <= '0;
      adc_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h1;
      adc_tick <= 1'b0;
    end
  end

  // First control register; rate, oversampling and fast-read fields frozen while active
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_sel <= MMC_RATE_RST;
      oversample_sel <= MMC_OVS_RST;
      fast_read_sel <= 1'b0;
      run_select <= 1'b0;
    end else if (wr_one) begin
      run_select <= reg_wdata_in[MMC_RUN_BIT];
      // Standby gate keeps config stable while run is set
      if (!run_select) begin
        rate_sel <= reg_wdata_in[MMC_RATE_HI:MMC_RATE_LO];
        oversample_sel <= reg_wdata_in[MMC_OVS_HI:MMC_OVS_LO];
        fast_read_sel <= reg_wdata_in[MMC_FAST_BIT];
      end
    end
  end

  // Trigger bit: set by host, cleared when its measurement ends
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trigger_meas <= 1'b0;
    end else if (wr_one && reg_wdata_in[MMC_TRIG_BIT]) begin
      trigger_meas <= 1'b1;
    end else if (state == MMC_MEAS && adc_tick && meas_cnt == 11'h1
                 && one_shot) begin
      // Cleared on the edge that ends the measurement, so idle never
      // sees a stale request and starts a second one
      trigger_meas <= 1'b0;
    end
  end

  // Second control register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      auto_sensor_refresh_on <= 1'b0;
      raw_sel <= 1'b0;
    end else if (wr_two) begin
      auto_sensor_refresh_on <= reg_wdata_in[MMC_AUTO_BIT];
      raw_sel <= reg_wdata_in[MMC_RAW_BIT];
    end
  end

  // Manual sensor reset; a new write wins over completion
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      srst_req <= 1'b0;
    end else if (wr_two && reg_wdata_in[MMC_SRST_BIT]) begin
      srst_req <= 1'b1;
    end else if (state == MMC_SRST && adc_tick && meas_cnt == 11'h1
                 && !(auto_sensor_refresh_on && (run_select ||
                      trigger_meas))) begin
      srst_req <= 1'b0;
    end
  end

  // Measurement sequencer, steps on converter ticks
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= MMC_IDLE;
      meas_cnt <= '0;
      gap_cnt <= '0;
      one_shot <= 1'b0;
      meas_start_out <= 1'b0;
      meas_done_out <= 1'b0;
      sensor_refresh_out <= 1'b0;
    end else begin
      meas_start_out <= 1'b0;
      meas_done_out <= 1'b0;
      case (state)
        MMC_IDLE: begin
          sensor_refresh_out <= 1'b0;
          if (srst_req) begin
            state <= MMC_SRST;
            meas_cnt <= 11'(MMC_SRST_TICKS);
            sensor_refresh_out <= 1'b1;
          end else if (run_select || trigger_meas) begin
            // Standby trigger starts at once
            // A pending trigger marks this measurement as the requested one
            one_shot <= trigger_meas;
            gap_cnt <= mmc_period_ticks(oversample_sel, rate_sel);
            if (auto_sensor_refresh_on) begin
              state <= MMC_SRST;
              meas_cnt <= 11'(MMC_SRST_TICKS);
              sensor_refresh_out <= 1'b1;
            end else begin
              state <= MMC_MEAS;
              meas_cnt <= mmc_ovs_ticks(oversample_sel);
              meas_start_out <= 1'b1;
            end
          end
        end
        MMC_SRST: begin
          if (adc_tick) begin
            meas_cnt <= meas_cnt - 11'h1;
            if (meas_cnt == 11'h1) begin
              sensor_refresh_out <= 1'b0;
              if (run_select || trigger_meas) begin
                state <= MMC_MEAS;
                meas_cnt <= mmc_ovs_ticks(oversample_sel);
                meas_start_out <= 1'b1;
              end else begin
                state <= MMC_IDLE;
              end
            end
          end
        end
        MMC_MEAS: begin
          if (adc_tick) begin
            meas_cnt <= meas_cnt - 11'h1;
            gap_cnt <= gap_cnt - 15'h1;
            if (meas_cnt == 11'h1) begin
              meas_done_out <= 1'b1;
              // Trigger while active cuts the idle gap
              if (one_shot || trigger_meas || !run_select) begin
                state <= MMC_IDLE;
              end else begin
                state <= MMC_WAIT;
              end
            end
          end
        end
        MMC_WAIT: begin
          if (!run_select) begin
            state <= MMC_IDLE;
          end else if (trigger_meas) begin
            state <= MMC_IDLE;
          end else if (adc_tick) begin
            gap_cnt <= gap_cnt - 15'h1;
            if (gap_cnt <= 15'h1) begin
              state <= MMC_IDLE;
            end
          end
        end
        default: begin
          state <= MMC_IDLE;
        end
      endcase
    end
  end

  // Offset correction and system state reporting
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_add_out <= 1'b1;
      system_state_out <= MMC_SYS_STANDBY;
    end else begin
      offset_add_out <= !raw_sel;
      if (!run_select) begin
        system_state_out <= MMC_SYS_STANDBY;
      end else if (raw_sel) begin
        system_state_out <= MMC_SYS_ACT_RAW;
      end else begin
        system_state_out <= MMC_SYS_ACT_COR;
      end
    end
  end

  // Burst address step: low bytes skipped in fast read
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      burst_next_out <= '0;
    end else if (burst_step_in) begin
      if (fast_read_sel && burst_addr_in >= MMC_ADDR_DATA_FIRST
          && burst_addr_in < MMC_ADDR_DATA_LAST - 8'h1) begin
        burst_next_out <= burst_addr_in + 8'h2;
      end else if (fast_read_sel && burst_addr_in == MMC_ADDR_DATA_LAST
                   - 8'h1) begin
        burst_next_out <= MMC_ADDR_DATA_LAST + 8'h1;
      end else begin
        burst_next_out <= burst_addr_in + 8'h1;
      end
    end
  end

  // Register read data; refresh bit always reads zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        MMC_ADDR_CTRL_ONE: reg_rdata_out <= {rate_sel, oversample_sel,
                              fast_read_sel, trigger_meas, run_select};
        MMC_ADDR_CTRL_TWO: reg_rdata_out <= {2'h0, raw_sel, srst_req,
                              4'h0};
        MMC_ADDR_SYS_STATE: reg_rdata_out <= {6'h00, system_state_out};
        default: reg_rdata_out <= '0;
      endcase
    end
  end
endmodule : mmc_measure_control
`default_nettype wire

//--- test/mmc_host.sv
// Host model driving the register and burst ports
`timescale 1ns/1ps
`default_nettype none
module mmc_host (
  // Clock
  input wire logic clk_sys_in,
  // Register and burst requests
  output logic wr_out, rd_out, step_out,
  output logic [7:0] addr_out, wdata_out, baddr_out,
  // Answers
  input wire logic [7:0] rdata_in, bnext_in
  );
  // Idle bus at time zero
  initial begin
    {wr_out, rd_out, step_out} = 3'h0;
    {addr_out, wdata_out, baddr_out} = 24'h0;
  end
  // Callers also write the rate fields while active, to check that they stay frozen
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_sys_in);
    wr_out = 1'b0;
    // Released data no longer shows the last value
    wdata_out = ~d;
  endtask : wr
  // Read: answer is registered one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_sys_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask : rd
  // Burst step request
  task automatic step(input logic [7:0] a, output logic [7:0] n);
    @(negedge clk_sys_in);
    baddr_out = a;
    step_out = 1'b1;
    @(negedge clk_sys_in);
    step_out = 1'b0;
    n = bnext_in;
  endtask : step
endmodule : mmc_host
`default_nettype wire

//--- test/mmc_measure_control_properties.sv
// Port-level assertion checker for the measurement control block
`timescale 1ns/1ps
`default_nettype none
module mmc_props
  import mmc_pkg::*;
  #(parameter int ADC_TICK_CYC = 4) (
  // Clock and reset
  input wire logic clk_sys_in, rst_b_in,
  // Register and burst ports
  input wire logic reg_wr_in, reg_rd_in, burst_step_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, burst_addr_in,
  input wire logic [7:0] reg_rdata_out, burst_next_out,
  // Front end
  input wire logic meas_start_out, sensor_refresh_out, offset_add_out,
  input wire logic meas_done_out,
  input wire logic [1:0] system_state_out
  );
  // Shortest and longest measurement, in cycles, with some slack
  localparam int MIN_D = 15 * ADC_TICK_CYC;
  localparam int MAX_D = 130 * ADC_TICK_CYC;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  chk_state_code: assert property (system_state_out != 2'h3)
    else $error("system state code out of range");
  chk_state_cor: assert property (system_state_out == MMC_SYS_ACT_COR
    |-> offset_add_out) else $error("corrected state without offsets");
  chk_state_raw: assert property (system_state_out == MMC_SYS_ACT_RAW
    |-> !offset_add_out) else $error("raw state with offsets");
  chk_state_read: assert property (reg_rd_in && reg_addr_in ==
    MMC_ADDR_SYS_STATE |=> reg_rdata_out == {6'h00, $past(system_state_out)})
    else $error("state register read mismatch");
  chk_ctrl_two_rd: assert property (reg_rd_in && reg_addr_in ==
    MMC_ADDR_CTRL_TWO |=> (reg_rdata_out & 8'hcf) == 8'h00)
    else $error("write-only or spare bits read nonzero");
  chk_burst_plain: assert property (burst_step_in && (burst_addr_in == 8'h00
    || burst_addr_in > 8'h05) |=> burst_next_out == $past(burst_addr_in)
    + 8'h01) else $error("burst step outside axis range");
  chk_meas_gap: assert property (meas_start_out |=> !meas_done_out [*8])
    else $error("measurement ended too early");
  chk_meas_bound: assert property (meas_start_out |-> ##[MIN_D:MAX_D]
    meas_done_out) else $error("measurement length out of range");
  chk_refresh_len: assert property ($rose(sensor_refresh_out) |=>
    sensor_refresh_out [*4]) else $error("sensor reset cycle too short");
endmodule : mmc_props
bind mmc_measure_control mmc_props #(.ADC_TICK_CYC(ADC_TICK_CYC)) u_props (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .burst_step_in(burst_step_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .burst_addr_in(burst_addr_in), .reg_rdata_out(reg_rdata_out),
  .burst_next_out(burst_next_out), .meas_start_out(meas_start_out),
  .sensor_refresh_out(sensor_refresh_out), .offset_add_out(offset_add_out),
  .meas_done_out(meas_done_out), .system_state_out(system_state_out));
`default_nettype wire

//--- test/mmc_measure_control_tb_top.sv
// Self-checking testbench for the measurement control block
`timescale 1ns/1ps
`default_nettype none
module mmc_measure_control_tb_top;
  import mmc_pkg::*;
  logic clk_sys_in, rst_b_in, wr, rd, step, start, refr, offs, done;
  logic [7:0] addr, wdata, rdata, baddr, bnext, d;
  logic [1:0] state;
  int fail_count, compares, n;
  // 125 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Short converter tick keeps the run brief
  mmc_measure_control #(.ADC_TICK_CYC(4)) u_mmc_measure_control (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .burst_step_in(step), .burst_addr_in(baddr),
    .burst_next_out(bnext), .meas_start_out(start),
    .sensor_refresh_out(refr), .offset_add_out(offs),
    .system_state_out(state), .meas_done_out(done));
  mmc_host u_mmc_host (.clk_sys_in(clk_sys_in), .wr_out(wr), .rd_out(rd),
    .step_out(step), .addr_out(addr), .wdata_out(wdata), .baddr_out(baddr),
    .rdata_in(rdata), .bnext_in(bnext));
  // Byte comparison
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("Compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait: 0 start, 1 done, 2 refresh idle, 3 standby, 4 refresh
  task automatic wait_ev(input int sel, output int k);
    logic hit;
    for (k = 1; k <= 3000; k++) begin
      @(negedge clk_sys_in);
      hit = sel == 0 ? start : sel == 1 ? done : sel == 2 ? !refr :
        sel == 3 ? state == MMC_SYS_STANDBY : refr;
      if (hit === 1'b1) return;
    end
    fail_count++;
    report_and_stop();
  endtask : wait_ev
  initial begin
    rst_b_in = 1'b0;
    fail_count = 0;
    compares = 0;
    repeat (8) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    chk("offset_add", 8'h01, {7'h0, offs});
    u_mmc_host.rd(MMC_ADDR_CTRL_ONE, d);
    chk("ctrl_one", MMC_CTRL_ONE_RST, d);
    u_mmc_host.rd(MMC_ADDR_CTRL_TWO, d);
    chk("ctrl_two", 8'h00, d);
    u_mmc_host.rd(8'h20, d);
    chk("unmapped", 8'h00, d);
    u_mmc_host.step(8'h01, d);
    chk("burst", 8'h02, d);
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h24);
    u_mmc_host.step(8'h01, d);
    chk("burst", 8'h03, d);
    u_mmc_host.step(8'h05, d);
    chk("burst", 8'h07, d);
    u_mmc_host.step(8'h06, d);
    chk("burst", 8'h07, d);
    // Periodic run: raw output, rate code 1, ratio 16
    u_mmc_host.wr(MMC_ADDR_CTRL_TWO, 8'h20);
    // Offset output is registered one cycle after the raw bit
    @(negedge clk_sys_in);
    chk("offset_add", 8'h00, {7'h0, offs});
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h25);
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'he1);
    u_mmc_host.rd(MMC_ADDR_CTRL_ONE, d);
    chk("ctrl_one", 8'h25, d);
    u_mmc_host.rd(MMC_ADDR_SYS_STATE, d);
    chk("state", {6'h0, MMC_SYS_ACT_RAW}, d);
    wait_ev(0, n);
    wait_ev(0, n);
    chk("period", 8'h80, n[7:0]);
    chk("period_hi", 8'h00, n[15:8]);
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h24);
    wait_ev(3, n);
    // One-shot in standby with automatic sensor reset
    u_mmc_host.wr(MMC_ADDR_CTRL_TWO, 8'ha0);
    u_mmc_host.rd(MMC_ADDR_CTRL_TWO, d);
    chk("ctrl_two", 8'h20, d);
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h02);
    wait_ev(4, n);
    wait_ev(0, n);
    u_mmc_host.rd(MMC_ADDR_CTRL_ONE, d);
    chk("ctrl_one", 8'h02, d);
    u_mmc_host.rd(MMC_ADDR_SYS_STATE, d);
    chk("state", {6'h0, MMC_SYS_STANDBY}, d);
    wait_ev(1, n);
    // A lone trigger must not start a second refresh or measurement
    repeat (4) begin
      @(negedge clk_sys_in);
      chk("no_restart", 8'h00, {6'h0, refr, start});
    end
    u_mmc_host.rd(MMC_ADDR_CTRL_ONE, d);
    chk("ctrl_one", 8'h00, d);
    // Manual sensor reset self-clears
    u_mmc_host.wr(MMC_ADDR_CTRL_TWO, 8'h10);
    u_mmc_host.rd(MMC_ADDR_CTRL_TWO, d);
    chk("ctrl_two", 8'h10, d);
    wait_ev(2, n);
    u_mmc_host.rd(MMC_ADDR_CTRL_TWO, d);
    chk("ctrl_two", 8'h00, d);
    // Corrected output while active
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h01);
    repeat (3) @(negedge clk_sys_in);
    u_mmc_host.rd(MMC_ADDR_SYS_STATE, d);
    chk("state", {6'h0, MMC_SYS_ACT_COR}, d);
    u_mmc_host.wr(MMC_ADDR_CTRL_ONE, 8'h03);
    wait_ev(0, n);
    // Trigger taken while active clears once its measurement is done
    wait_ev(1, n);
    u_mmc_host.rd(MMC_ADDR_CTRL_ONE, d);
    chk("ctrl_one", 8'h01, d);
    report_and_stop();
  end
endmodule : mmc_measure_control_tb_top
`default_nettype wire
